/* File: design/vacs_pkg.sv */
/*
 * Constants and types for the video RAM address and CAS select stage.
 * Assumes a single 100 MHz clock and an APB slave for status access.
 */
package vacs_pkg;
   localparam int ADDR_W    = 11;
   localparam int BANK_W    = 2;
   localparam int NCAS      = 4;
   localparam int SYNC_W    = 2 * ADDR_W + BANK_W + 2 + 3;
   // ************************************************************
   // programming register layout
   // ************************************************************
   localparam int PRG_W        = 23;
   localparam int PRG_ROW_LSB  = 0;
   localparam int PRG_COL_LSB  = 10;
   localparam int PRG_BANK_LSB = 20;
   localparam int PRG_ECAS0    = 22;
   localparam int PRG_MODE_LSB = 0;
   localparam logic [PRG_W-1:0] PRG_RST = 23'h000000;
   // bank arrangement codes
   localparam logic [1:0] MODE_ONE  = 2'h0;
   localparam logic [1:0] MODE_TWO  = 2'h1;
   localparam logic [1:0] MODE_FOUR = 2'h2;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PROG = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_ADDR = 8'h0c;
   localparam int CTRL_EN  = 0;
   localparam logic CTRL_RST = 1'b1;
   localparam int ADDR_COL_LSB = 16;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_PROG  = 5'b00010,
      ST_ACC   = 5'b00100,
      ST_EXT   = 5'b01000,
      ST_SCRUB = 5'b10000
   } vacs_state_t;
endpackage : vacs_pkg

/* File: design/vacs_sync.sv */
/*
 * Two-flop synchroniser, one per bit.
 * Assumes every bit is an independent level from outside the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module vacs_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,   // system clock
   input  wire logic         arst_n,  // async reset
   input  wire logic [W-1:0] d_in,    // asynchronous levels
   input  wire logic [W-1:0] rst_val, // constant reset levels
   output logic      [W-1:0] q_out    // synchronised levels
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic hold_r;
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               meta_r <= 1'b0;
               hold_r <= 1'b0;
            end else begin
               meta_r <= d_in[i] ^ rst_val[i];
               hold_r <= meta_r;
            end
         end
         // kept relative to the reset level so the reset stays constant
         assign q_out[i] = hold_r ^ rst_val[i];
      end
   endgenerate
endmodule : vacs_sync
`default_nettype wire

/* File: design/vacs_bank_decode.sv */
/*
 * Bank decode: maps bank select and arrangement to RAS and CAS groups.
 * Purely combinational; assumes registered inputs from the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module vacs_bank_decode
   import vacs_pkg::*;
(
   input  wire logic [1:0]      mode,    // bank arrangement
   input  wire logic [BANK_W-1:0] bank,  // bank select
   output logic      [NCAS-1:0] ras_sel, // RAS group, high = use
   output logic      [NCAS-1:0] cas_sel  // CAS group, high = use
);
   always_comb begin
      // one bank of 32 bits: all four strobes together
      ras_sel = 4'hf;
      cas_sel = 4'hf;
      if (mode == MODE_TWO) begin
         ras_sel = bank[0] ? 4'hc : 4'h3;
         cas_sel = bank[0] ? 4'hc : 4'h3;
      end else if (mode == MODE_FOUR || mode == 2'h3) begin
         // spare code treated as four banks
         ras_sel = 4'h1 << bank;
         cas_sel = 4'h1 << bank;
      end
   end
endmodule : vacs_bank_decode
`default_nettype wire

/* File: design/vacs_top.sv */
/*
 * Address and CAS select stage of a video RAM controller: captures the
 * row, column and bank inputs, loads the programming register, and
 * gates the RAS/CAS groups during accesses, extension and scrubbing.
 * Assumes the internal RAS/CAS generators and the scrub sequencer run
 * on the same clock; host pins are asynchronous and synchronised here.
 * Address pins are synchronised bit by bit, so the host must hold them
 * steady from before a request until the access has started.
 */
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vacs_top
   import vacs_pkg::*;
(
   input  wire logic              clock,             // 100 MHz
   input  wire logic              arst_n,            // async reset
   input  wire logic [ADDR_W-1:0] row_addr_in,       // row address pins
   input  wire logic [ADDR_W-1:0] col_addr_in,       // column pins
   input  wire logic [BANK_W-1:0] bank_select_in,    // bank pins
   input  wire logic [1:0]        cas_enable_in_n,   // CAS enables
   input  wire logic              program_load_n,    // program load
   input  wire logic              port_a_access_req_n, // port A req
   input  wire logic              port_b_access_req_n, // port B req
   input  wire logic              ras_gen_in,        // RAS timing
   input  wire logic              cas_gen_in,        // CAS timing
   input  wire logic              xfer_in,           // transfer cycle
   input  wire logic              scrub_in,          // scrub refresh
   input  wire logic [BANK_W-1:0] scrub_bank_in,     // scrub bank
   input  wire logic              psel,              // APB select
   input  wire logic              penable,           // APB enable
   input  wire logic              pwrite,            // APB write
   input  wire logic [7:0]        paddr,             // APB address
   input  wire logic [31:0]       pwdata,            // APB wdata
   output logic                   pready,            // APB ready
   output logic      [31:0]       prdata,            // APB rdata
   output logic                   pslverr,           // APB error
   output logic      [NCAS-1:0]   ras_out_n,         // RAS strobes
   output logic      [NCAS-1:0]   cas_out_n,         // CAS strobes
   output logic      [ADDR_W-1:0] row_addr_out,      // latched row
   output logic      [ADDR_W-1:0] col_addr_out,      // latched col
   output logic      [PRG_W-1:0]  prog_out           // programming
);
   // ************************************************************
   // pin synchronisation
   // ************************************************************
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic [SYNC_W-1:0] pins_rst;
   logic [ADDR_W-1:0] row_s;
   logic [ADDR_W-1:0] col_s;
   logic [BANK_W-1:0] bank_s;
   logic [1:0]        ecas_n_s;
   logic              ml_n_s;
   logic              port_a_access_req_n_s;
   logic              breq_n_s;

   assign pins_raw = {port_b_access_req_n, port_a_access_req_n,
                      program_load_n, cas_enable_in_n,
                      bank_select_in, col_addr_in, row_addr_in};
   // control strobes are active low and must idle high
   assign pins_rst = {5'h1f, {(SYNC_W-5){1'b0}}};

   vacs_sync #(.W(SYNC_W)) u_sync (
      .clock   (clock),
      .arst_n  (arst_n),
      .d_in    (pins_raw),
      .rst_val (pins_rst),
      .q_out   (pins_s)
   );

   assign row_s    = pins_s[ADDR_W-1:0];
   assign col_s    = pins_s[2*ADDR_W-1:ADDR_W];
   assign bank_s   = pins_s[2*ADDR_W+BANK_W-1:2*ADDR_W];
   assign ecas_n_s = pins_s[2*ADDR_W+BANK_W+1:2*ADDR_W+BANK_W];
   assign ml_n_s   = pins_s[SYNC_W-3];
   assign port_a_access_req_n_s = pins_s[SYNC_W-2];
   assign breq_n_s = pins_s[SYNC_W-1];

   logic       req;
   logic [1:0] ecas_on;
   // either port starts an access; port arbitration sits upstream
   assign req     = ~port_a_access_req_n_s | ~breq_n_s;
   assign ecas_on = ~ecas_n_s;

   // ************************************************************
   // control register and programming register
   // ************************************************************
   logic             enable_r;
   logic [PRG_W-1:0] prog_r;
   logic [PRG_W-1:0] prog_nxt;
   logic [1:0]       mode;
   logic             ext_ok;

   // data from pins, top bits dropped
   always_comb begin
      prog_nxt = '0;
      prog_nxt[PRG_ROW_LSB +: 10]    = row_s[9:0];
      prog_nxt[PRG_COL_LSB +: 10]    = col_s[9:0];
      prog_nxt[PRG_BANK_LSB +: BANK_W] = bank_s;
      prog_nxt[PRG_ECAS0]            = ecas_on[0];
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prog_r <= PRG_RST;
      end else if (!ml_n_s) begin
         prog_r <= prog_nxt;
      end
   end

   assign mode   = prog_r[PRG_MODE_LSB +: 2];
   // extension armed by enable 0 negated
   assign ext_ok = ~prog_r[PRG_ECAS0];

   // ************************************************************
   // access sequencing
   // ************************************************************
   vacs_state_t state_r;
   vacs_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (!ml_n_s) begin
               state_nxt = ST_PROG;
            end else if (scrub_in) begin
               state_nxt = ST_SCRUB;
            end else if (req && enable_r) begin
               state_nxt = ST_ACC;
            end
         end
         ST_PROG: begin
            if (ml_n_s) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_ACC: begin
            if (!req) begin
               state_nxt = (ext_ok && ecas_on[0]) ? ST_EXT : ST_IDLE;
            end
         end
         ST_EXT: begin
            if (!ecas_on[0]) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_SCRUB: begin
            if (!scrub_in) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ************************************************************
   // address and bank latch
   // ************************************************************
   logic              start;
   logic [BANK_W-1:0] bank_r;

   // transfer latches only with load released, so programming data
   // is never taken for a transfer address
   assign start = (state_r == ST_IDLE) &&
                  (state_nxt == ST_ACC || state_nxt == ST_SCRUB ||
                   (xfer_in && ml_n_s));

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         row_addr_out <= '0;
      end else if (start) begin
         row_addr_out <= row_s;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         col_addr_out <= '0;
      end else if (start && state_nxt != ST_SCRUB) begin
         col_addr_out <= col_s;
      end
   end

   // bank frozen for the whole access so RAS never hops banks
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bank_r <= '0;
      end else if (start) begin
         bank_r <= bank_s;
      end
   end

   // ************************************************************
   // RAS and CAS group gating
   // ************************************************************
   logic [BANK_W-1:0] dec_bank;
   logic [NCAS-1:0]   ras_sel;
   logic [NCAS-1:0]   cas_sel;
   logic [NCAS-1:0]   cas_gate;
   logic [NCAS-1:0]   ras_nxt;
   logic [NCAS-1:0]   cas_nxt;

   // scrubs bypass the access latch; the scrub sequencer owns the bank
   assign dec_bank = (state_r == ST_SCRUB) ? scrub_bank_in : bank_r;

   vacs_bank_decode u_dec (
      .mode    (mode),
      .bank    (dec_bank),
      .ras_sel (ras_sel),
      .cas_sel (cas_sel)
   );

   // enable 0 for pair 0/1, enable 1 for 2/3
   // each pair gated on its own
   assign cas_gate = {ecas_on[1], ecas_on[1], ecas_on[0], ecas_on[0]};

   always_comb begin
      ras_nxt = 4'h0;
      cas_nxt = 4'h0;
      case (state_r)
         ST_ACC: begin
            ras_nxt = ras_gen_in ? ras_sel : 4'h0;
            cas_nxt = cas_gen_in ? (cas_sel & cas_gate) : 4'h0;
         end
         ST_EXT: begin
            cas_nxt = cas_sel & cas_gate;
         end
         ST_SCRUB: begin
            ras_nxt = ras_gen_in ? 4'hf : 4'h0;
            cas_nxt = cas_gen_in ? cas_sel : 4'h0;
         end
         default: begin
            ras_nxt = 4'h0;
            cas_nxt = 4'h0;
         end
      endcase
   end

   // strobes come from flops, which costs one cycle
   // between the generators and the pins
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ras_out_n <= 4'hf;
         cas_out_n <= 4'hf;
      end else begin
         ras_out_n <= ~ras_nxt;
         cas_out_n <= ~cas_nxt;
      end
   end

   // copy lags the programming register by one cycle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prog_out <= PRG_RST;
      end else begin
         prog_out <= prog_r;
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************
   logic        acc_phase;
   logic        hit;
   logic [31:0] rd_nxt;

   // one wait state so read data can come from a flop
   assign acc_phase = psel & penable & ~pready;

   always_comb begin
      hit    = 1'b1;
      rd_nxt = 32'h0;
      if (paddr == OFS_CTRL) begin
         rd_nxt[CTRL_EN] = enable_r;
      end else if (paddr == OFS_PROG) begin
         rd_nxt[PRG_W-1:0] = prog_r;
      end else if (paddr == OFS_STAT) begin
         rd_nxt = {12'h0, state_r, bank_r,
                   cas_out_n, ras_out_n,
                   ecas_n_s, ml_n_s, breq_n_s, port_a_access_req_n_s};
      end else if (paddr == OFS_ADDR) begin
         rd_nxt = {5'h0, col_addr_out, 5'h0, row_addr_out};
      end else begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc_phase;
         pslverr <= acc_phase & ~hit;
         prdata  <= (acc_phase && !pwrite && hit) ? rd_nxt : 32'h0;
      end
   end

   // only CTRL is writable; PROG, STAT and ADDR drop writes silently, unmapped offsets raise pslverr
   // write takes effect at the edge that completes the transfer
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         enable_r <= CTRL_RST;
      end else if (psel && penable && pready && pwrite &&
                   paddr == OFS_CTRL) begin
         enable_r <= pwdata[CTRL_EN];
      end
   end
endmodule : vacs_top
`default_nettype wire

/* File: test/vacs_host_model.sv */
/*
 * Host pin model: address, bank, CAS enables, load and requests.
 * Assumes the bench calls its tasks one at a time, after an edge.
 */
`timescale 1ns/1ps
`default_nettype none
module vacs_host_model
   import vacs_pkg::*;
(
   input  wire logic              clock,               // system clock
   output logic      [ADDR_W-1:0] row_addr_in,         // row pins
   output logic      [ADDR_W-1:0] col_addr_in,         // column pins
   output logic      [BANK_W-1:0] bank_select_in,      // bank pins
   output logic      [1:0]        cas_enable_in_n,     // CAS enables
   output logic                   program_load_n,      // load strobe
   output logic                   port_a_access_req_n, // port A req
   output logic                   port_b_access_req_n  // port B req
);
   initial begin
      row_addr_in = 11'h000;
      col_addr_in = 11'h000;
      bank_select_in = 2'h0;
      cas_enable_in_n = 2'h3;
      program_load_n = 1'b1;
      port_a_access_req_n = 1'b1;
      port_b_access_req_n = 1'b1;
   end
   task automatic load(input logic [10:0] r, input logic [10:0] c,
                       input logic [1:0] b, input logic e0_n);
      @(posedge clock);
      row_addr_in <= r;
      col_addr_in <= c;
      bank_select_in <= b;
      cas_enable_in_n <= {1'b1, e0_n};
      program_load_n <= 1'b0;
      repeat (4) @(posedge clock);
      program_load_n <= 1'b1;
      repeat (4) @(posedge clock);
      // released bus: show the inverse, never the old data
      row_addr_in <= ~r;
      col_addr_in <= ~c;
      bank_select_in <= ~b;
   endtask : load
   task automatic request(input logic pb, input logic on,
                          input logic [10:0] r, input logic [10:0] c,
                          input logic [1:0] b);
      @(posedge clock);
      row_addr_in <= r;
      col_addr_in <= c;
      bank_select_in <= b;
      if (pb) port_b_access_req_n <= !on;
      else port_a_access_req_n <= !on;
   endtask : request
   task automatic enables(input logic [1:0] e_n);
      @(posedge clock);
      cas_enable_in_n <= e_n;
   endtask : enables
endmodule : vacs_host_model
`default_nettype wire

/* File: test/vacs_top_sva.sv */
/*
 * Checker for the CAS select stage: strobe causes, APB handshake.
 * Assumes it is bound to vacs_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module vacs_top_sva
   import vacs_pkg::*;
(
   input wire logic              clock,           // system clock
   input wire logic              arst_n,          // async reset
   input wire logic [1:0]        cas_enable_in_n, // CAS enables
   input wire logic              program_load_n,  // program load
   input wire logic              ras_gen_in,      // RAS timing
   input wire logic              cas_gen_in,      // CAS timing
   input wire logic              scrub_in,        // scrub refresh
   input wire logic              psel,            // APB select
   input wire logic              penable,         // APB enable
   input wire logic              pready,          // APB ready
   input wire logic              pslverr,         // APB error
   input wire logic [NCAS-1:0]   ras_out_n,       // RAS strobes
   input wire logic [NCAS-1:0]   cas_out_n,       // CAS strobes
   input wire logic [PRG_W-1:0]  prog_out         // programming
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // scrub excluded: enables are ignored there
   cas_lo_gate_a: assert property (
      !(&cas_out_n[1:0]) && !scrub_in && !$past(scrub_in)
      |-> !$past(cas_enable_in_n[0], 3)) else $error("cas0/1 ungated");
   cas_hi_gate_a: assert property (
      !(&cas_out_n[3:2]) && !scrub_in && !$past(scrub_in)
      |-> !$past(cas_enable_in_n[1], 3)) else $error("cas2/3 ungated");
   ras_gen_a: assert property (
      ras_out_n != 4'hf |-> $past(ras_gen_in))
      else $error("ras without generator");
   cas_gen_a: assert property (
      cas_out_n != 4'hf |-> $past(cas_gen_in))
      else $error("cas without generator");
   prog_hold_a: assert property (
      program_load_n [*6] |=> $stable(prog_out))
      else $error("programming changed without load");
   apb_wait_a: assert property (
      psel && penable && !pready |=> pready) else $error("no ready");
   ready_pulse_a: assert property (
      pready |=> !pready) else $error("ready too long");
   ready_cause_a: assert property (
      pready |-> $past(psel) && $past(penable)) else $error("stray ready");
   err_ready_a: assert property (
      pslverr |-> pready) else $error("error without ready");
endmodule : vacs_top_sva
bind vacs_top vacs_top_sva i_vacs_top_sva (.clock, .arst_n,
   .cas_enable_in_n, .program_load_n, .ras_gen_in, .cas_gen_in,
   .scrub_in, .psel, .penable, .pready, .pslverr, .ras_out_n,
   .cas_out_n, .prog_out);
`default_nettype wire

/* File: test/tb_top.sv */
/*
 * Bench for the CAS select stage: APB register checks, programming,
 * bank groups, byte lanes, extension and scrubbing.
 * Assumes vacs_top, its checker and the host pin model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import vacs_pkg::*;
;
   logic clock, arst_n, ras_gen_in, cas_gen_in, xfer_in, scrub_in;
   logic psel, penable, pwrite, pready, pslverr, program_load_n, err;
   logic port_a_access_req_n, port_b_access_req_n;
   logic [BANK_W-1:0] scrub_bank_in, bank_select_in;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NCAS-1:0] ras_out_n, cas_out_n;
   logic [ADDR_W-1:0] row_addr_in, col_addr_in, row_addr_out, col_addr_out;
   logic [1:0] cas_enable_in_n;
   logic [PRG_W-1:0] prog_out, pe;
   int n_errors = 0;
   int checks = 0;
   vacs_top i_vacs_top (.clock, .arst_n, .row_addr_in, .col_addr_in,
      .bank_select_in, .cas_enable_in_n, .program_load_n,
      .port_a_access_req_n, .port_b_access_req_n, .ras_gen_in,
      .cas_gen_in, .xfer_in, .scrub_in, .scrub_bank_in, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .ras_out_n,
      .cas_out_n, .row_addr_out, .col_addr_out, .prog_out);
   vacs_host_model i_vacs_host_model (.clock, .row_addr_in, .col_addr_in,
      .bank_select_in, .cas_enable_in_n, .program_load_n,
      .port_a_access_req_n, .port_b_access_req_n);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk("apb_ready", 0, 1);
   endtask : apb
   task automatic strobe_wait();
      int n;
      n = 0;
      while (ras_out_n === 4'hf && n < 30) begin
         @(posedge clock);
         n++;
      end
      chk("ras_seen", n < 30, 1);
      repeat (3) @(posedge clock);
   endtask : strobe_wait
   function automatic logic [3:0] grp(input int m, input int b);
      if (m == 0) return 4'h0;
      if (m == 1) return b[0] ? 4'h3 : 4'hc;
      return ~(4'h1 << b);
   endfunction : grp
   // watchdog: whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      report_and_stop();
   end
   initial begin
      arst_n = 1'b0;
      {ras_gen_in, cas_gen_in, xfer_in, scrub_in} = 4'h0;
      {psel, penable, pwrite, scrub_bank_in} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      chk("ras_rst", ras_out_n, 4'hf);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", rd, {31'h0, CTRL_RST});
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl_wr", rd, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b1, OFS_PROG, 32'hffffffff);
      apb(1'b0, OFS_PROG, 32'h0);
      chk("prog_ro", rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      $display("test registers done");
      for (int m = 0; m < 3; m++) begin
         i_vacs_host_model.load({1'b1, 8'h5a, m[1:0]}, 11'h6c3, 2'h2, 1'b0);
         pe = {1'b1, 2'h2, 10'h2c3, 8'h5a, m[1:0]};
         chk("prog_pin", prog_out, pe);
         apb(1'b0, OFS_PROG, 32'h0);
         chk("prog_reg", rd, {9'h0, pe});
         for (int b = 0; b < 4; b++) begin
            i_vacs_host_model.enables(2'h0);
            i_vacs_host_model.request(b[0], 1'b1, {9'h100, b[1:0]},
                                      {9'h1fc, b[1:0]}, b[1:0]);
            ras_gen_in <= 1'b1;
            cas_gen_in <= 1'b1;
            strobe_wait();
            chk("ras_grp", ras_out_n, grp(m, b));
            chk("cas_grp", cas_out_n, grp(m, b));
            chk("row_lat", row_addr_out, {9'h100, b[1:0]});
            chk("col_lat", col_addr_out, {9'h1fc, b[1:0]});
            ras_gen_in <= 1'b0;
            cas_gen_in <= 1'b0;
            i_vacs_host_model.request(b[0], 1'b0, {9'h100, b[1:0]},
                                      {9'h1fc, b[1:0]}, b[1:0]);
            repeat (6) @(posedge clock);
         end
      end
      apb(1'b0, OFS_ADDR, 32'h0);
      chk("addr_reg", rd, {5'h0, 11'h7f3, 5'h0, 11'h403});
      $display("test bank groups done");
      i_vacs_host_model.load(11'h000, 11'h000, 2'h0, 1'b1);
      i_vacs_host_model.request(1'b0, 1'b1, 11'h001, 11'h002, 2'h0);
      ras_gen_in <= 1'b1;
      cas_gen_in <= 1'b1;
      strobe_wait();
      for (int e = 0; e < 4; e++) begin
         i_vacs_host_model.enables(e[1:0]);
         repeat (4) @(posedge clock);
         chk("cas_lane", cas_out_n, {e[1], e[1], e[0], e[0]});
      end
      i_vacs_host_model.enables(2'h2);
      repeat (4) @(posedge clock);
      i_vacs_host_model.request(1'b0, 1'b0, 11'h001, 11'h002, 2'h0);
      repeat (5) @(posedge clock);
      chk("ext_ras", ras_out_n, 4'hf);
      chk("ext_cas", cas_out_n, 4'hc);
      i_vacs_host_model.enables(2'h3);
      repeat (5) @(posedge clock);
      chk("ext_end", cas_out_n, 4'hf);
      ras_gen_in <= 1'b0;
      cas_gen_in <= 1'b0;
      $display("test lanes and extension done");
      repeat (3) @(posedge clock);
      i_vacs_host_model.load(11'h002, 11'h000, 2'h0, 1'b1);
      scrub_bank_in <= 2'h1;
      scrub_in <= 1'b1;
      @(posedge clock);
      ras_gen_in <= 1'b1;
      cas_gen_in <= 1'b1;
      repeat (4) @(posedge clock);
      chk("scrub_ras", ras_out_n, 4'h0);
      chk("scrub_cas", cas_out_n, 4'hd);
      ras_gen_in <= 1'b0;
      cas_gen_in <= 1'b0;
      repeat (3) @(posedge clock);
      scrub_in <= 1'b0;
      $display("test scrub done");
      i_vacs_host_model.request(1'b0, 1'b0, 11'h2a5, 11'h35a, 2'h0);
      repeat (3) @(posedge clock);
      xfer_in <= 1'b1;
      @(posedge clock);
      xfer_in <= 1'b0;
      repeat (2) @(posedge clock);
      chk("xfer_row", row_addr_out, 11'h2a5);
      chk("xfer_col", col_addr_out, 11'h35a);
      $display("test transfer latch done");
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
